// >>> src/bfs_top.v
// Function
// - a supply undervoltage trip disables both outputs, sets supply_low_flag, resets all config and goes to output-off.
// - an enabled output falling below the falling power-good level sets its output_low_fault_flag.
// - an enabled output kept under the rising power-good level past the timeout is disabled and its config reset.
// - an enabled output below the short threshold is disabled, sets short_fault_flag and has its config reset.
// - a thermal trip disables all outputs, sets overtemp_flag and resets all config.
// - power-good and short results are ignored while a converter ramps up or down.
// - after a timeout, short or thermal fault the converter goes from reset to held-off or wait by auto_restart_sel.
// - in held-off the converter stays off until pin, bit and overtemp_status are all low, then goes to output-off.
// - in wait the converter stays off for 500 ms, then goes to output-off once overtemp_status is clear.
// - entering output-off from wait with the enable still true starts soft-start and moves to output-on.
// - each of the two converters has its own independently triggered fault state machine.
// - each power_good_pin is an active-high open-drain indication of output quality.
// - when unmasked, output_low_fault_flag sets on every 1 to 0 change of output_good_status.
// - output_good_status rises only after soft-start and above the rising level, and falls below the falling level.
`timescale 1ns/1ps
`include "bfs_consts.vh"

module bfs_top #(
  parameter [22:0] WAIT_CYCLES = `BFS_WAIT_MS * 1000000 / `BFS_CLK_NS,
  parameter [22:0] POK_CYCLES  = `BFS_POK_TO_US * 1000 / `BFS_CLK_NS
) (
  input  wire       sys_clk_i,
  input  wire       rstn_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  output wire [7:0] reg_rdata_o,
  input  wire       supply_low_i,
  input  wire       overtemp_i,
  input  wire [1:0] output_enable_pin_i,
  input  wire [1:0] ramping_i,
  input  wire [1:0] above_rise_i,
  input  wire [1:0] below_fall_i,
  input  wire [1:0] below_short_i,
  output wire [1:0] buck_enable_o,
  output wire [1:0] cfg_reset_o,
  input  wire [1:0] power_good_pin_i,
  output wire [1:0] power_good_pin_o,
  output wire [1:0] power_good_pin_oe_o,
  output wire       irq_o
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  reg  [5:0] msk_q;
  reg  [5:0] msk_d;
  reg        auto_q;
  reg        auto_d;
  reg  [1:0] enbit_q;
  reg  [1:0] enbit_d;
  reg  [7:0] rdata_q;
  reg  [7:0] rdata_d;
  reg        low_prev_q;
  reg        ovt_prev_q;
  reg        irq_q;
  reg  [1:0] pgoe_q;
  wire [5:0] int_flags;
  wire [5:0] int_set;
  wire [5:0] int_clr;
  wire       low_rise;
  wire       ovt_rise;
  wire [1:0] conv_cfg_rst;
  wire [1:0] good;
  wire [1:0] good_fall;
  wire [1:0] short_evt;
  wire [4:0] state0;
  wire [4:0] state1;
  wire [1:0] olf_set;

  //////////////////////////////////////////////////////////////////////////////
  // one fault machine per converter

  // converter 0, triggered only by its own monitors and the shared trips
  bfs_conv_fsm #(
    .WAIT_CYCLES (WAIT_CYCLES),
    .POK_CYCLES  (POK_CYCLES)
  ) u_fsm0 (
    .sys_clk_i      (sys_clk_i),
    .rstn_i         (rstn_i),
    .supply_low_i   (supply_low_i),
    .overtemp_i     (overtemp_i),
    .auto_restart_i (auto_q),
    .enable_pin_i   (output_enable_pin_i[0]),
    .enable_bit_i   (enbit_q[0]),
    .ramping_i      (ramping_i[0]),
    .above_rise_i   (above_rise_i[0]),
    .below_fall_i   (below_fall_i[0]),
    .below_short_i  (below_short_i[0]),
    .out_enable_o   (buck_enable_o[0]),
    .cfg_reset_o    (conv_cfg_rst[0]),
    .good_o         (good[0]),
    .good_fall_o    (good_fall[0]),
    .short_evt_o    (short_evt[0]),
    .state_o        (state0)
  );

  // converter 1, same machine, independent state
  bfs_conv_fsm #(
    .WAIT_CYCLES (WAIT_CYCLES),
    .POK_CYCLES  (POK_CYCLES)
  ) u_fsm1 (
    .sys_clk_i      (sys_clk_i),
    .rstn_i         (rstn_i),
    .supply_low_i   (supply_low_i),
    .overtemp_i     (overtemp_i),
    .auto_restart_i (auto_q),
    .enable_pin_i   (output_enable_pin_i[1]),
    .enable_bit_i   (enbit_q[1]),
    .ramping_i      (ramping_i[1]),
    .above_rise_i   (above_rise_i[1]),
    .below_fall_i   (below_fall_i[1]),
    .below_short_i  (below_short_i[1]),
    .out_enable_o   (buck_enable_o[1]),
    .cfg_reset_o    (conv_cfg_rst[1]),
    .good_o         (good[1]),
    .good_fall_o    (good_fall[1]),
    .short_evt_o    (short_evt[1]),
    .state_o        (state1)
  );

  //////////////////////////////////////////////////////////////////////////////
  // trip edges and config reset

  // comparator edges raise the global flags once per trip
  assign low_rise = supply_low_i & ~low_prev_q;
  assign ovt_rise = overtemp_i & ~ovt_prev_q;

  // config defaults: all on supply or thermal trip, one on its own fault
  assign cfg_reset_o[0] = conv_cfg_rst[0] | supply_low_i | ovt_rise;
  assign cfg_reset_o[1] = conv_cfg_rst[1] | supply_low_i | ovt_rise;

  //////////////////////////////////////////////////////////////////////////////
  // interrupt flags

  // output-low flag only sets while its mask bit is clear
  assign olf_set = good_fall & ~msk_q[`BFS_INT_OLF+1:`BFS_INT_OLF];

  // event collection into the sticky status group
  assign int_set[`BFS_INT_LOW]                 = low_rise;
  assign int_set[`BFS_INT_OVT]                 = ovt_rise;
  assign int_set[`BFS_INT_OLF+1:`BFS_INT_OLF]  = olf_set;
  assign int_set[`BFS_INT_SHF+1:`BFS_INT_SHF]  = short_evt;

  // a read of the interrupt status register clears it
  assign int_clr = (reg_rd_i && reg_addr_i == `BFS_ADDR_INT) ? 6'h3F : 6'h00;

  bfs_flag #(
    .W (`BFS_INT_W)
  ) u_int (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .set_i     (int_set),
    .clr_i     (int_clr),
    .flag_o    (int_flags)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register writes

  // software writes, hardware config reset wins over a same-cycle write
  always @* begin
    msk_d   = msk_q;
    auto_d  = auto_q;
    enbit_d = enbit_q;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `BFS_ADDR_MSK: begin
          msk_d = reg_wdata_i[5:0];
        end
        `BFS_ADDR_CFG: begin
          auto_d = reg_wdata_i[`BFS_CFG_AUTO];
        end
        `BFS_ADDR_EN: begin
          enbit_d = reg_wdata_i[1:0];
        end
        default: begin
          msk_d = msk_q;
        end
      endcase
    end
    if (cfg_reset_o[0]) begin
      enbit_d[0] = 1'b0;
    end
    if (cfg_reset_o[1]) begin
      enbit_d[1] = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register reads

  // read data stand in the cycle after the strobe, zero otherwise
  always @* begin
    rdata_d = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `BFS_ADDR_INT: begin
          rdata_d = {2'h0, int_flags};
        end
        `BFS_ADDR_MSK: begin
          rdata_d = {2'h0, msk_q};
        end
        `BFS_ADDR_STAT: begin
          rdata_d = {2'h0, power_good_pin_i, good, overtemp_i, supply_low_i};
        end
        `BFS_ADDR_CFG: begin
          rdata_d = {7'h00, auto_q};
        end
        `BFS_ADDR_EN: begin
          rdata_d = {6'h00, enbit_q};
        end
        `BFS_ADDR_FSM0: begin
          rdata_d = {3'h0, state0};
        end
        `BFS_ADDR_FSM1: begin
          rdata_d = {3'h0, state1};
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // storage

  // registers, edge detectors, interrupt and pin drivers
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      msk_q      <= `BFS_MSK_RST;
      auto_q     <= `BFS_AUTO_RST;
      enbit_q    <= `BFS_EN_RST;
      rdata_q    <= 8'h00;
      low_prev_q <= 1'b0;
      ovt_prev_q <= 1'b0;
      irq_q      <= 1'b0;
      pgoe_q     <= 2'h3;
    end else begin
      msk_q      <= msk_d;
      auto_q     <= auto_d;
      enbit_q    <= enbit_d;
      rdata_q    <= rdata_d;
      low_prev_q <= supply_low_i;
      ovt_prev_q <= overtemp_i;
      irq_q      <= |(int_set | (int_flags & ~int_clr)) & |((int_set | (int_flags & ~int_clr)) & ~msk_q);
      pgoe_q     <= ~good;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  // open drain: pull low while not good, release so the pull-up shows high
  assign power_good_pin_o    = 2'h0;
  assign power_good_pin_oe_o = pgoe_q;
  assign reg_rdata_o         = rdata_q;
  assign irq_o               = irq_q;

endmodule

// >>> inc/bfs_consts.vh
`ifndef BFS_CONSTS_VH
`define BFS_CONSTS_VH

// clock period in ns
`define BFS_CLK_NS      100
// forced-off interval of the wait state, ms
`define BFS_WAIT_MS     500
// power-good timeout, us
`define BFS_POK_TO_US   1000

// register offsets
`define BFS_ADDR_INT    8'h00
`define BFS_ADDR_MSK    8'h01
`define BFS_ADDR_STAT   8'h02
`define BFS_ADDR_CFG    8'h03
`define BFS_ADDR_EN     8'h04
`define BFS_ADDR_FSM0   8'h05
`define BFS_ADDR_FSM1   8'h06

// interrupt status and mask bit positions
`define BFS_INT_LOW     0
`define BFS_INT_OVT     1
`define BFS_INT_OLF     2
`define BFS_INT_SHF     4
`define BFS_INT_W       6

// config and status bit positions
`define BFS_CFG_AUTO    0
`define BFS_STAT_LOW    0
`define BFS_STAT_OVT    1
`define BFS_STAT_GOOD   2
`define BFS_STAT_PIN    4

// reset values
`define BFS_MSK_RST     6'h00
`define BFS_AUTO_RST    1'b0
`define BFS_EN_RST      2'h0

`endif

// >>> src/bfs_flag.v
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// sticky flag group: set wins over clear in the same cycle
module bfs_flag #(
  parameter W = 6
) (
  input  wire         sys_clk_i,
  input  wire         rstn_i,
  input  wire [W-1:0] set_i,
  input  wire [W-1:0] clr_i,
  output wire [W-1:0] flag_o
);

  reg [W-1:0] flag_q;
  wire [W-1:0] flag_d;

  // clear first, then set, so a simultaneous event is kept
  assign flag_d = (flag_q & ~clr_i) | set_i;
  assign flag_o = flag_q;

  // flag storage
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_q <= {W{1'b0}};
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule

// >>> src/bfs_conv_fsm.v
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// fault state machine of one converter
module bfs_conv_fsm #(
  parameter [22:0] WAIT_CYCLES = 23'h4C4B40,
  parameter [22:0] POK_CYCLES  = 23'h002710
) (
  input  wire       sys_clk_i,
  input  wire       rstn_i,
  input  wire       supply_low_i,
  input  wire       overtemp_i,
  input  wire       auto_restart_i,
  input  wire       enable_pin_i,
  input  wire       enable_bit_i,
  input  wire       ramping_i,
  input  wire       above_rise_i,
  input  wire       below_fall_i,
  input  wire       below_short_i,
  output wire       out_enable_o,
  output wire       cfg_reset_o,
  output wire       good_o,
  output wire       good_fall_o,
  output wire       short_evt_o,
  output wire [4:0] state_o
);

  localparam [4:0] ST_OFF  = 5'h01;
  localparam [4:0] ST_ON   = 5'h02;
  localparam [4:0] ST_RST  = 5'h04;
  localparam [4:0] ST_HELD = 5'h08;
  localparam [4:0] ST_WAIT = 5'h10;

  reg  [4:0]  st_q;
  reg  [4:0]  st_d;
  reg  [22:0] cnt_q;
  reg  [22:0] cnt_d;
  reg         good_q;
  reg         good_d;
  reg         fall_q;
  reg         short_q;
  reg         short_d;
  wire        en_req;
  wire        monitor;
  wire        pok_to;

  // either the pin or the bit requests the output
  assign en_req  = enable_pin_i | enable_bit_i;
  // comparators ignored while ramping
  assign monitor = (st_q == ST_ON) && !ramping_i;
  assign pok_to  = monitor && !above_rise_i && (cnt_q == POK_CYCLES);

  // next state, shared counter, good level
  always @* begin
    st_d    = st_q;
    cnt_d   = 23'h000000;
    short_d = 1'b0;
    good_d  = good_q;
    if (st_q != ST_ON) begin
      good_d = 1'b0;
    end else if (monitor && below_fall_i) begin
      good_d = 1'b0;
    end else if (monitor && above_rise_i) begin
      good_d = 1'b1;
    end
    case (st_q)
      ST_OFF: begin
        if (en_req && !overtemp_i) begin
          st_d = ST_ON;
        end
      end
      ST_ON: begin
        if (monitor && !above_rise_i) begin
          cnt_d = cnt_q + 23'h000001;
        end
        if (overtemp_i) begin
          st_d = ST_RST;
        end else if (monitor && below_short_i) begin
          st_d    = ST_RST;
          short_d = 1'b1;
        end else if (pok_to) begin
          st_d = ST_RST;
        end else if (!en_req) begin
          st_d = ST_OFF;
        end
      end
      ST_RST: begin
        st_d = auto_restart_i ? ST_WAIT : ST_HELD;
      end
      ST_HELD: begin
        if (!enable_pin_i && !enable_bit_i && !overtemp_i) begin
          st_d = ST_OFF;
        end
      end
      ST_WAIT: begin
        cnt_d = (cnt_q == WAIT_CYCLES) ? cnt_q : cnt_q + 23'h000001;
        if ((cnt_q == WAIT_CYCLES) && !overtemp_i) begin
          st_d = ST_OFF;
        end
      end
      default: begin
        st_d = ST_OFF;
      end
    endcase
    if (supply_low_i) begin
      st_d  = ST_OFF;
      cnt_d = 23'h000000;
    end
  end

  // state registers, output-off after reset
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q    <= ST_OFF;
      cnt_q   <= 23'h000000;
      good_q  <= 1'b0;
      fall_q  <= 1'b0;
      short_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      good_q  <= good_d;
      fall_q  <= good_q & ~good_d;
      short_q <= short_d;
    end
  end

  assign out_enable_o = (st_q == ST_ON);
  assign cfg_reset_o  = (st_q == ST_RST);
  assign good_o       = good_q;
  assign good_fall_o  = fall_q;
  assign short_evt_o  = short_q;
  assign state_o      = st_q;

endmodule

// >>> verification/bfs_top_chk.sv
`timescale 1ns/1ps
////////////////////////////////////////
// pin-level checks of both fault machines
module bfs_top_chk (
  input wire       sys_clk_i,
  input wire       rstn_i,
  input wire       supply_low_i,
  input wire       overtemp_i,
  input wire [1:0] output_enable_pin_i,
  input wire [1:0] ramping_i,
  input wire [1:0] below_short_i,
  input wire [1:0] buck_enable_o,
  input wire [1:0] cfg_reset_o,
  input wire [1:0] power_good_pin_o,
  input wire [1:0] power_good_pin_oe_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // supply trip turns both outputs off and holds config reset
  AST_SUPPLY_OFF: assert property (supply_low_i |=> buck_enable_o == 2'b00)
    else $error("output on after supply trip");
  AST_SUPPLY_CFG: assert property (supply_low_i |-> cfg_reset_o == 2'b11)
    else $error("config not reset during supply trip");
  // short on one converter: that one off, config reset, then held off
  AST_SHORT0: assert property (buck_enable_o[0] && !ramping_i[0] && below_short_i[0] && !supply_low_i
    |=> (!buck_enable_o[0] && cfg_reset_o[0]) ##1 !buck_enable_o[0] [*2])
    else $error("short on output 0 not handled");
  AST_SHORT1: assert property (buck_enable_o[1] && !ramping_i[1] && below_short_i[1] && !supply_low_i
    |=> (!buck_enable_o[1] && cfg_reset_o[1]) ##1 !buck_enable_o[1] [*2])
    else $error("short on output 1 not handled");
  // thermal trip
  AST_OVT_OFF: assert property (overtemp_i |=> buck_enable_o == 2'b00)
    else $error("output on while hot");
  AST_OVT_CFG: assert property ($rose(overtemp_i) |-> cfg_reset_o == 2'b11)
    else $error("config not reset on thermal trip");
  // monitors of output 0 are ignored while ramping
  AST_RAMP_HOLD: assert property (buck_enable_o[0] && ramping_i[0] && output_enable_pin_i[0]
    && !supply_low_i && !overtemp_i |=> buck_enable_o[0])
    else $error("output 0 dropped while ramping");
  // converter 0, once off for three cycles, reports not good
  AST_IDLE_PULL: assert property ((!buck_enable_o[0]) [*3] |-> power_good_pin_oe_o[0])
    else $error("good pin released while output off");
  AST_OPEN_DRAIN: assert property (power_good_pin_o == 2'b00)
    else $error("good pin driven high");
endmodule

// >>> verification/bfs_stage_model.sv
`timescale 1ns/1ps
////////////////////////////////////////
// power stages and monitors of both converters
module bfs_stage_model #(
  parameter [3:0] RAMP = 4'h6
) (
  input  wire       sys_clk_i,
  input  wire       rstn_i,
  input  wire [1:0] en_i,
  input  wire [1:0] short_cmd_i,
  input  wire [1:0] sag_cmd_i,
  output wire [1:0] ramping_o,
  output wire [1:0] above_rise_o,
  output wire [1:0] below_fall_o,
  output wire [1:0] below_short_o
);
  reg [1:0] en_q;
  reg [3:0] r0_q;
  reg [3:0] r1_q;
  wire [1:0] ok;

  // soft-start or soft-stop runs after each enable change
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_q <= 2'h0;
      r0_q <= 4'h0;
      r1_q <= 4'h0;
    end else begin
      en_q <= en_i;
      r0_q <= (en_i[0] != en_q[0]) ? RAMP : ((r0_q != 4'h0) ? r0_q - 4'h1 : 4'h0);
      r1_q <= (en_i[1] != en_q[1]) ? RAMP : ((r1_q != 4'h0) ? r1_q - 4'h1 : 4'h0);
    end
  end

  // comparator results from a settled or faulted output
  assign ramping_o     = {r1_q != 4'h0, r0_q != 4'h0} | (en_i ^ en_q);
  assign ok            = en_i & ~ramping_o & ~sag_cmd_i & ~short_cmd_i;
  assign above_rise_o  = ok;
  assign below_fall_o  = ~ok;
  assign below_short_o = ~en_i | short_cmd_i;
endmodule

// >>> verification/bfs_top_tb.sv
`timescale 1ns/1ps
////////////////////////////////////////
// self-checking bench of the fault machines
module bfs_top_tb;
  localparam [22:0] WAIT = 23'h000014;
  localparam [22:0] POK  = 23'h000008;
  localparam        RAMP = 6;
  reg        sys_clk_i, rstn_i, reg_wr_i, reg_rd_i, supply_low_i, overtemp_i;
  reg  [7:0] reg_addr_i, reg_wdata_i, d;
  reg  [1:0] pin, short_cmd, sag_cmd;
  wire [7:0] reg_rdata_o;
  wire [1:0] ramp, rise, fall, shrt, be, cfg_rst, pg_o, pg_oe;
  wire       irq_o;
  wire [1:0] pg_wire = ~pg_oe;
  integer    n_errors, checked, cyc, i, n, t0;

  bfs_top #(.WAIT_CYCLES(WAIT), .POK_CYCLES(POK)) bfs_top_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .supply_low_i(supply_low_i), .overtemp_i(overtemp_i),
    .output_enable_pin_i(pin), .ramping_i(ramp), .above_rise_i(rise), .below_fall_i(fall),
    .below_short_i(shrt), .buck_enable_o(be), .cfg_reset_o(cfg_rst), .power_good_pin_i(pg_wire),
    .power_good_pin_o(pg_o), .power_good_pin_oe_o(pg_oe), .irq_o(irq_o));
  bfs_stage_model #(.RAMP(RAMP)) bfs_stage_model_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .en_i(be),
    .short_cmd_i(short_cmd), .sag_cmd_i(sag_cmd), .ramping_o(ramp), .above_rise_o(rise),
    .below_fall_o(fall), .below_short_o(shrt));

  // clock and hang guard
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_errors = n_errors + 1;
      summarize;
    end
  end

  // expected register images
  function [7:0] int_exp(input sl, input ovt, input [1:0] olf, input [1:0] shf);
    int_exp = {2'h0, shf, olf, ovt, sl};
  endfunction
  function [7:0] stat_exp(input sl, input ovt, input [1:0] good);
    stat_exp = {2'h0, good, good, ovt, sl};
  endfunction

  // compare, bus cycles and waits
  task chk(input [7:0] got, input [7:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input [7:0] a, output [7:0] v);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
    v = reg_rdata_o;
  endtask
  task wait_be(input [1:0] e);
    n = 0;
    @(posedge sys_clk_i);
    while (be !== e && n < 100) begin
      @(posedge sys_clk_i);
      n = n + 1;
    end
  endtask
  task cycles(input integer k);
    repeat (k) @(posedge sys_clk_i);
  endtask
  task summarize;
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // main sequence
  initial begin
    {rstn_i, reg_wr_i, reg_rd_i, supply_low_i, overtemp_i} = 5'h00;
    {reg_addr_i, reg_wdata_i, d, pin, short_cmd, sag_cmd} = 30'h00000000;
    {n_errors, checked, cyc} = 0;
    n = $urandom(34711);
    cycles(2);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    chk(be, 2'h0);
    chk(pg_oe, 2'h3);
    for (i = 1; i < 8; i = i + 1) begin
      rd(i[7:0], d);
      chk(d, (i == 5 || i == 6) ? 8'h01 : 8'h00);
    end
    // both on, random short pulse while ramping
    pin <= 2'h1;
    wr(8'h04, 8'h02);
    wait_be(2'h3);
    chk(be, 2'h3);
    short_cmd <= $urandom % 4;
    @(posedge sys_clk_i);
    short_cmd <= 2'h0;
    cycles(RAMP + 4);
    chk(be, 2'h3);
    rd(8'h02, d);
    chk(d, stat_exp(0, 0, 2'h3));
    // sag on output 0 until timeout, latched off
    sag_cmd <= 2'h1;
    wait_be(2'h2);
    chk(be, 2'h2);
    cycles(3);
    chk(irq_o, 1'b1);
    rd(8'h00, d);
    chk(d, int_exp(0, 0, 2'h1, 2'h0));
    rd(8'h00, d);
    chk(d, 8'h00);
    rd(8'h05, d);
    chk(d, 8'h08);
    rd(8'h04, d);
    chk(d, 8'h02);
    pin <= 2'h0;
    sag_cmd <= 2'h0;
    cycles(3);
    rd(8'h05, d);
    chk(d, 8'h01);
    // short with auto restart
    wr(8'h03, 8'h01);
    pin <= 2'h1;
    wait_be(2'h3);
    cycles(RAMP + 4);
    short_cmd <= 2'h1;
    wait_be(2'h2);
    short_cmd <= 2'h0;
    t0 = cyc;
    rd(8'h05, d);
    chk(d, 8'h10);
    wait_be(2'h3);
    chk(be, 2'h3);
    chk((cyc - t0 >= WAIT) && (cyc - t0 <= WAIT + 6), 1'b1);
    rd(8'h00, d);
    chk(d, int_exp(0, 0, 2'h1, 2'h1));
    // masked output-low event on output 1
    wr(8'h01, 8'h08);
    cycles(RAMP + 4);
    sag_cmd <= 2'h2;
    wait_be(2'h1);
    chk(be, 2'h1);
    cycles(4);
    chk(irq_o, 1'b0);
    rd(8'h00, d);
    chk(d, 8'h00);
    rd(8'h04, d);
    chk(d, 8'h00);
    sag_cmd <= 2'h0;
    wr(8'h04, 8'h02);
    wait_be(2'h3);
    cycles(RAMP + 4);
    // settled short on output 1, only its own config cleared
    short_cmd <= 2'h2;
    wait_be(2'h1);
    short_cmd <= 2'h0;
    chk(be, 2'h1);
    rd(8'h00, d);
    chk(d, int_exp(0, 0, 2'h0, 2'h2));
    rd(8'h04, d);
    chk(d, 8'h00);
    // thermal trip held past the wait time
    overtemp_i <= 1'b1;
    cycles(2);
    chk(be, 2'h0);
    cycles(WAIT + 5);
    rd(8'h05, d);
    chk(d, 8'h10);
    overtemp_i <= 1'b0;
    wait_be(2'h1);
    chk(be, 2'h1);
    rd(8'h00, d);
    chk(d, int_exp(0, 1, 2'h1, 2'h0));
    // supply trip
    cycles(RAMP + 4);
    supply_low_i <= 1'b1;
    cycles(3);
    chk(be, 2'h0);
    chk(cfg_rst, 2'h3);
    rd(8'h05, d);
    chk(d, 8'h01);
    rd(8'h02, d);
    chk(d, stat_exp(1, 0, 2'h0));
    supply_low_i <= 1'b0;
    rd(8'h00, d);
    chk(d, int_exp(1, 0, 2'h1, 2'h0));
    summarize;
  end
endmodule

bind bfs_top bfs_top_chk bfs_top_chk_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .supply_low_i(supply_low_i),
  .overtemp_i(overtemp_i), .output_enable_pin_i(output_enable_pin_i), .ramping_i(ramping_i),
  .below_short_i(below_short_i), .buck_enable_o(buck_enable_o), .cfg_reset_o(cfg_reset_o),
  .power_good_pin_o(power_good_pin_o), .power_good_pin_oe_o(power_good_pin_oe_o));
